// ===== core/pmode_defs.svh
// Purpose: constants for the power mode and wake-up controller
// Assumes: 100 MHz core_clk
// Notes:   offsets are register byte addresses
`ifndef PMODE_DEFS_SVH
`define PMODE_DEFS_SVH
`define PM_CLK_MHZ        100
`define PM_N_MON          5
`define PM_N_GPIO         4
`define PM_N_WAKE         11
`define PM_WD_FAIL_LIMIT  3'h4
// registers (byte addresses)
`define PM_MODE_CTRL      8'h00
`define PM_CYC_CFG        8'h04
`define PM_CYC_PERIOD     8'h08
`define PM_WAKE_EN        8'h0c
`define PM_EDGE_RISE      8'h10
`define PM_EDGE_FALL      8'h14
`define PM_WAKE_STAT      8'h18
`define PM_WAKE_MASK      8'h1c
`define PM_STATUS         8'h20
`define PM_SENSE_REF      8'h24
// mode control fields
`define PM_MC_STOP        0
`define PM_MC_SLEEP       1
// cyclic config fields
`define PM_CC_WAKE        0
`define PM_CC_SENSE       1
`define PM_CC_CMP_REF     2
`define PM_CC_EXT         3
// wake vector layout: bit 0 lin, 1..5 mon, 6..9 gpio, 10 timer
`define PM_WB_LIN         0
`define PM_WB_MON         1
`define PM_WB_GPIO        6
`define PM_WB_TIMER       10
// reset values
`define PM_WAKE_EN_RST    11'h43f
`define PM_EDGE_RISE_RST  11'h7ff
`define PM_EDGE_FALL_RST  11'h000
`define PM_PERIOD_RST     16'h0064
// timing: sense window and one period tick in microseconds
`define PM_SENSE_US       10
`define PM_SENSE_CYC      (`PM_SENSE_US * `PM_CLK_MHZ)
`define PM_TICK_US        10
`define PM_TICK_CYC       (`PM_TICK_US * `PM_CLK_MHZ)
`endif

// ===== core/pmode_pkg.sv
// Purpose: types for the power mode and wake-up controller
// Assumes: nothing
// Notes:   constants live in pmode_defs.svh
package pmode_pkg;
  typedef enum logic [2:0] {
    MODE_RESET, MODE_ACTIVE, MODE_STOP, MODE_SLEEP, MODE_WAKE
  } mode_type;
  typedef struct packed {
    logic pre_regulator_on;
    logic pad_supply_on;
    logic core_supply_on;
    logic core_supply_low;
    logic cpu_clk_on;
    logic pll_on;
    logic modules_on;
    logic meas_on;
    logic watchdog_on;
    logic cpu_reset;
  } power_ctrl_type;
  typedef struct packed {
    logic       lin;
    logic [4:0] mon;
    logic [3:0] gpio;
  } wake_in_type;
endpackage

// ===== core/wake_latch.sv
// Purpose: per-source sync, edge select and sticky flag
// Assumes: raw inputs asynchronous
// Notes:   set beats write-one-to-clear
`timescale 1ns/10ps
`default_nettype none
`include "pmode_defs.svh"
module wake_latch (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic [`PM_N_WAKE-1:0]  raw_in,
  input  wire logic [`PM_N_WAKE-1:0]  rise_en,
  input  wire logic [`PM_N_WAKE-1:0]  fall_en,
  input  wire logic [`PM_N_WAKE-1:0]  src_en,
  input  wire logic [`PM_N_WAKE-1:0]  clr,
  output logic      [`PM_N_WAKE-1:0]  level,
  output logic      [`PM_N_WAKE-1:0]  hit,
  output logic      [`PM_N_WAKE-1:0]  flag
);
  logic [1:0] arm_cnt_r;
  // edges ignored until sync and prev hold the pin: no false edge after reset,
  // but a pin change before the first sample after reset is lost
  wire        arm_w = (arm_cnt_r == 2'h3);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      arm_cnt_r <= 2'h0;
    end else if (!arm_w) begin
      arm_cnt_r <= arm_cnt_r + 2'h1;
    end
  end
  genvar i;
  generate
    for (i = 0; i < `PM_N_WAKE; i++) begin : g_src
      logic meta_r;
      logic sync_r;
      logic prev_r;
      logic flag_r;
      wire  rise_w = sync_r & ~prev_r;
      wire  fall_w = ~sync_r & prev_r;
      // first stage feeds only the second
      wire  hit_w  = arm_w & src_en[i] &
                     ((rise_en[i] & rise_w) | (fall_en[i] & fall_w));
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
          flag_r <= 1'b0;
        end else begin
          meta_r <= raw_in[i];
          sync_r <= meta_r;
          prev_r <= sync_r;
          flag_r <= hit_w | (flag_r & ~clr[i]);
        end
      end
      assign level[i] = sync_r;
      assign hit[i]   = hit_w;
      assign flag[i]  = flag_r;
    end
  endgenerate
endmodule // wake_latch
`default_nettype wire

// ===== core/cyclic_timer.sv
// Purpose: programmable period timer with sense window
// Assumes: run held high while in a cyclic low-power mode
// Notes:   period counted in ticks
`timescale 1ns/10ps
`default_nettype none
`include "pmode_defs.svh"
module cyclic_timer (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        run,
  input  wire logic [15:0] period,
  output logic             expire,
  output logic             window,
  output logic             window_end
);
  logic [15:0] tick_cnt_r;
  logic [15:0] per_cnt_r;
  logic [15:0] win_cnt_r;
  wire         tick_w = (tick_cnt_r == 16'(`PM_TICK_CYC - 1));
  wire         per_done_w = tick_w & (per_cnt_r >= period - 16'h0001);
  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      tick_cnt_r <= 16'h0000;
      per_cnt_r  <= 16'h0000;
      win_cnt_r  <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_w ? 16'h0000 : tick_cnt_r + 16'h0001;
      if (per_done_w) begin
        per_cnt_r <= 16'h0000;
        win_cnt_r <= 16'(`PM_SENSE_CYC);
      end else begin
        if (tick_w) begin
          per_cnt_r <= per_cnt_r + 16'h0001;
        end
        if (win_cnt_r != 16'h0000) begin
          win_cnt_r <= win_cnt_r - 16'h0001;
        end
      end
    end
  end
  assign expire     = run & per_done_w;
  assign window     = (win_cnt_r != 16'h0000);
  assign window_end = (win_cnt_r == 16'h0001);
endmodule // cyclic_timer
`default_nettype wire

// ===== core/power_mode_wakeup_control.sv
// Purpose: power mode sequencing and wake-up management
// Assumes: one 100 MHz clock standing in for the low-power oscillator
// Notes:   register port with one-cycle read latency
`timescale 1ns/10ps
`default_nettype none
`include "pmode_defs.svh"
module power_mode_wakeup_control (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire pmode_pkg::wake_in_type wake_in,
  input  wire logic                   core_supply_good,
  input  wire logic                   watchdog_fail,
  output pmode_pkg::power_ctrl_type   power_ctrl,
  output logic                        high_side_output,
  output logic                        external_sensor_supply,
  output logic                        irq
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  pmode_pkg::mode_type     mode_r;
  pmode_pkg::mode_type     mode_nxt;
  pmode_pkg::power_ctrl_type pc_r;
  pmode_pkg::power_ctrl_type pc_nxt;
  logic [1:0]              mode_req_r;
  logic [3:0]              cyc_cfg_r;
  logic [15:0]             period_r;
  logic [`PM_N_WAKE-1:0]   wake_en_r;
  logic [`PM_N_WAKE-1:0]   rise_r;
  logic [`PM_N_WAKE-1:0]   fall_r;
  logic [`PM_N_WAKE-1:0]   mask_r;
  logic [`PM_N_WAKE-1:0]   sense_ref_r;
  logic [`PM_N_WAKE-1:0]   sense_prev_r;
  logic [2:0]              wd_cnt_r;
  logic                    sleep_wake_r;
  logic                    hs_r;
  logic                    ext_r;
  logic [31:0]             rdata_r;
  logic                    cyc_wake_r;
  logic                    cyc_sense_r;
  ////////////////////////////////////////////////////////////////////////////
  // wake sources
  wire logic [`PM_N_WAKE-1:0] raw_w;
  wire logic [`PM_N_WAKE-1:0] level_w;
  wire logic [`PM_N_WAKE-1:0] hit_w;
  wire logic [`PM_N_WAKE-1:0] flag_w;
  wire logic [`PM_N_WAKE-1:0] clr_w;
  wire logic [`PM_N_WAKE-1:0] mode_en_w;
  wire logic                  timer_expire_w;
  wire logic                  window_w;
  wire logic                  window_end_w;
  wire logic                  in_low_w = (mode_r == pmode_pkg::MODE_STOP) ||
                                         (mode_r == pmode_pkg::MODE_SLEEP);
  wire logic                  timer_run_w = in_low_w & (cyc_wake_r | cyc_sense_r);
  assign raw_w = {timer_expire_w & cyc_wake_r, wake_in.gpio, wake_in.mon, wake_in.lin};
  // gpios are no wake source in sleep
  assign mode_en_w = (mode_r == pmode_pkg::MODE_SLEEP) ?
                     (wake_en_r & ~(11'h00f << `PM_WB_GPIO)) : wake_en_r;
  wake_latch u_wake_latch (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .raw_in   (raw_w),
    .rise_en  (rise_r | (11'h001 << `PM_WB_TIMER)),
    .fall_en  (fall_r),
    .src_en   (mode_en_w),
    .clr      (clr_w),
    .level    (level_w),
    .hit      (hit_w),
    .flag     (flag_w)
  );
  cyclic_timer u_cyclic_timer (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .run        (timer_run_w),
    .period     (period_r),
    .expire     (timer_expire_w),
    .window     (window_w),
    .window_end (window_end_w)
  );
  ////////////////////////////////////////////////////////////////////////////
  // cyclic sense compare on monitor levels, plus gpio levels in stop only, at window end
  wire logic [`PM_N_WAKE-1:0] sense_sel_w = wake_en_r & 11'h3fe &
                                  ((mode_r == pmode_pkg::MODE_STOP) ? 11'h3fe : 11'h03e);
  wire logic sense_trig_w = cyc_sense_r & window_end_w &
                            (cyc_cfg_r[`PM_CC_CMP_REF] ?
                             (((level_w ^ sense_ref_r) & sense_sel_w) == '0) :
                             (((level_w ^ sense_prev_r) & sense_sel_w) != '0));
  // equal priority: any source, first one wins, no ordering
  wire logic wake_any_w = in_low_w & ((|hit_w) | sense_trig_w);
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic wr_mode_w  = reg_wr && (reg_addr == `PM_MODE_CTRL);
  wire logic wr_cyc_w   = reg_wr && (reg_addr == `PM_CYC_CFG);
  wire logic wr_per_w   = reg_wr && (reg_addr == `PM_CYC_PERIOD);
  wire logic wr_en_w    = reg_wr && (reg_addr == `PM_WAKE_EN);
  wire logic wr_rise_w  = reg_wr && (reg_addr == `PM_EDGE_RISE);
  wire logic wr_fall_w  = reg_wr && (reg_addr == `PM_EDGE_FALL);
  wire logic wr_stat_w  = reg_wr && (reg_addr == `PM_WAKE_STAT);
  wire logic wr_mask_w  = reg_wr && (reg_addr == `PM_WAKE_MASK);
  wire logic wr_ref_w   = reg_wr && (reg_addr == `PM_SENSE_REF);
  assign clr_w = wr_stat_w ? reg_wdata[`PM_N_WAKE-1:0] : '0;
  logic [31:0] rd_sel_w;
  always_comb begin
    rd_sel_w = 32'h0000_0000;
    if (reg_addr == `PM_MODE_CTRL) begin
      rd_sel_w = {30'h0, mode_req_r};
    end else if (reg_addr == `PM_CYC_CFG) begin
      rd_sel_w = {28'h0, cyc_cfg_r};
    end else if (reg_addr == `PM_CYC_PERIOD) begin
      rd_sel_w = {16'h0, period_r};
    end else if (reg_addr == `PM_WAKE_EN) begin
      rd_sel_w = {21'h0, wake_en_r};
    end else if (reg_addr == `PM_EDGE_RISE) begin
      rd_sel_w = {21'h0, rise_r};
    end else if (reg_addr == `PM_EDGE_FALL) begin
      rd_sel_w = {21'h0, fall_r};
    end else if (reg_addr == `PM_WAKE_STAT) begin
      rd_sel_w = {21'h0, flag_w};
    end else if (reg_addr == `PM_WAKE_MASK) begin
      rd_sel_w = {21'h0, mask_r};
    end else if (reg_addr == `PM_STATUS) begin
      rd_sel_w = {13'h0, level_w, sleep_wake_r, wd_cnt_r, 1'b0, 3'(mode_r)};
    end else if (reg_addr == `PM_SENSE_REF) begin
      rd_sel_w = {21'h0, sense_ref_r};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // mode sequencer
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      pmode_pkg::MODE_RESET: begin
        if (watchdog_fail && wd_cnt_r >= `PM_WD_FAIL_LIMIT) begin
          mode_nxt = pmode_pkg::MODE_SLEEP;
        end else if (core_supply_good) begin
          mode_nxt = pmode_pkg::MODE_ACTIVE;
        end
      end
      pmode_pkg::MODE_ACTIVE: begin
        if (mode_req_r[`PM_MC_SLEEP]) begin
          mode_nxt = pmode_pkg::MODE_SLEEP;
        end else if (mode_req_r[`PM_MC_STOP]) begin
          mode_nxt = pmode_pkg::MODE_STOP;
        end
      end
      pmode_pkg::MODE_STOP: begin
        if (wake_any_w) begin
          mode_nxt = pmode_pkg::MODE_ACTIVE;
        end
      end
      pmode_pkg::MODE_SLEEP: begin
        if (wake_any_w) begin
          mode_nxt = pmode_pkg::MODE_RESET;
        end
      end
      default: begin
        mode_nxt = pmode_pkg::MODE_RESET;
      end
    endcase
  end
  always_comb begin
    pc_nxt = '0;
    case (mode_nxt)
      pmode_pkg::MODE_RESET: begin
        pc_nxt.pre_regulator_on = 1'b1;
        pc_nxt.pad_supply_on    = 1'b1;
        pc_nxt.core_supply_on   = 1'b1;
        pc_nxt.cpu_reset        = 1'b1;
      end
      pmode_pkg::MODE_ACTIVE: begin
        pc_nxt = '1;
        pc_nxt.core_supply_low = 1'b0;
        pc_nxt.cpu_reset       = 1'b0;
        pc_nxt.meas_on         = 1'b1;
      end
      pmode_pkg::MODE_STOP: begin
        pc_nxt.pre_regulator_on = 1'b1;
        pc_nxt.pad_supply_on    = 1'b1;
        pc_nxt.core_supply_on   = 1'b1;
        pc_nxt.core_supply_low  = 1'b1;
      end
      default: begin
        pc_nxt = '0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // state and register updates; all logic on the one always-on clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r       <= pmode_pkg::MODE_RESET;
      pc_r         <= '0;
      wd_cnt_r     <= 3'h0;
      sleep_wake_r <= 1'b0;
      cyc_wake_r   <= 1'b0;
      cyc_sense_r  <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      pc_r   <= pc_nxt;
      if (mode_r != pmode_pkg::MODE_RESET) begin
        wd_cnt_r <= 3'h0;
      end else if (watchdog_fail && wd_cnt_r != 3'h7) begin
        wd_cnt_r <= wd_cnt_r + 3'h1;
      end
      if (mode_r == pmode_pkg::MODE_SLEEP && mode_nxt == pmode_pkg::MODE_RESET) begin
        sleep_wake_r <= 1'b1;
      end else if (wr_mode_w) begin
        sleep_wake_r <= 1'b0;
      end
      // cyclic flavour latched at command time, so bits must precede it
      if (mode_r == pmode_pkg::MODE_ACTIVE && mode_nxt != pmode_pkg::MODE_ACTIVE) begin
        cyc_wake_r  <= cyc_cfg_r[`PM_CC_WAKE];
        cyc_sense_r <= cyc_cfg_r[`PM_CC_SENSE];
      end else if (!in_low_w) begin
        cyc_wake_r  <= 1'b0;
        cyc_sense_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_req_r  <= 2'h0;
      cyc_cfg_r   <= 4'h0;
      period_r    <= `PM_PERIOD_RST;
      wake_en_r   <= `PM_WAKE_EN_RST;
      rise_r      <= `PM_EDGE_RISE_RST;
      fall_r      <= `PM_EDGE_FALL_RST;
      mask_r      <= '0;
      sense_ref_r <= '0;
    end else begin
      if (mode_r != pmode_pkg::MODE_ACTIVE) begin
        mode_req_r <= 2'h0;
      end else if (wr_mode_w) begin
        mode_req_r <= reg_wdata[1:0];
      end
      if (wr_cyc_w) cyc_cfg_r <= reg_wdata[3:0];
      if (wr_per_w) period_r <= reg_wdata[15:0];
      if (wr_en_w) wake_en_r <= reg_wdata[`PM_N_WAKE-1:0];
      if (wr_rise_w) rise_r <= reg_wdata[`PM_N_WAKE-1:0];
      if (wr_fall_w) fall_r <= reg_wdata[`PM_N_WAKE-1:0];
      if (wr_mask_w) mask_r <= reg_wdata[`PM_N_WAKE-1:0];
      if (wr_ref_w) sense_ref_r <= reg_wdata[`PM_N_WAKE-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // cyclic sense outputs and previous sample
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hs_r         <= 1'b0;
      ext_r        <= 1'b0;
      sense_prev_r <= '0;
      rdata_r      <= 32'h0000_0000;
    end else begin
      hs_r  <= cyc_sense_r & window_w;
      ext_r <= cyc_sense_r & window_w & cyc_cfg_r[`PM_CC_EXT] &
               (mode_r == pmode_pkg::MODE_STOP);
      if (cyc_sense_r && window_end_w) begin
        sense_prev_r <= level_w;
      end else if (!in_low_w) begin
        sense_prev_r <= level_w;
      end
      rdata_r <= reg_rd ? rd_sel_w : 32'h0000_0000;
    end
  end
  assign power_ctrl             = pc_r;
  assign high_side_output       = hs_r;
  assign external_sensor_supply = ext_r;
  assign reg_rdata              = rdata_r;
  assign irq                    = |(flag_w & mask_r);
endmodule // power_mode_wakeup_control
`default_nettype wire

// ===== dv/pmode_checker_sva.sv
// Purpose: port checks for the power mode controller
// Assumes: one clock domain, sync reset
// Notes:   bound onto the top module below
`timescale 1ns/10ps
`default_nettype none
module pmode_checker (
  input wire logic                      core_clk,
  input wire logic                      sys_rst,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire pmode_pkg::wake_in_type    wake_in,
  input wire logic                      core_supply_good,
  input wire pmode_pkg::power_ctrl_type power_ctrl,
  input wire logic                      high_side_output,
  input wire logic                      external_sensor_supply
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_rdata_slot: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
  a_active_all_on: assert property (
    power_ctrl.modules_on |-> power_ctrl.meas_on && power_ctrl.pll_on && !power_ctrl.cpu_reset)
    else $error("active without all modules");
  a_stop_clocks: assert property (
    power_ctrl.core_supply_low |-> !power_ctrl.pll_on && !power_ctrl.cpu_clk_on)
    else $error("stop with clocks running");
  a_stop_powered: assert property (
    power_ctrl.core_supply_low |-> power_ctrl.core_supply_on) else $error("stop lost cpu power");
  a_sleep_dark: assert property (
    !power_ctrl.core_supply_on |-> !power_ctrl.modules_on && !power_ctrl.cpu_clk_on)
    else $error("modules on without core");
  a_active_entry: assert property (
    $rose(power_ctrl.modules_on) |-> core_supply_good) else $error("active before supply good");
  a_stop_entry: assert property (
    $rose(power_ctrl.core_supply_low) |-> $past(power_ctrl.modules_on))
    else $error("stop not entered from active");
  a_sense_low: assert property (
    $rose(high_side_output) |-> !power_ctrl.modules_on) else $error("sense pulse in active");
  a_ext_window: assert property (
    external_sensor_supply |-> high_side_output && power_ctrl.core_supply_on)
    else $error("sensor supply outside window");
  a_wake_sync: assert property (
    $changed(wake_in) && !power_ctrl.modules_on |=> (!power_ctrl.modules_on)[*2])
    else $error("wake bypassed synchroniser");
  // main scenarios reached
  c_stop: cover property ($rose(power_ctrl.core_supply_low));
  c_sense: cover property ($rose(high_side_output));
  c_sleep: cover property ($fell(power_ctrl.core_supply_on));
endmodule // pmode_checker
bind power_mode_wakeup_control pmode_checker i_pmode_checker (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wake_in(wake_in), .core_supply_good(core_supply_good), .power_ctrl(power_ctrl),
  .high_side_output(high_side_output), .external_sensor_supply(external_sensor_supply));
`default_nettype wire

// ===== dv/pins_model.sv
// Purpose: far-side pins: supply monitor and wake lines
// Assumes: wake lines are plain levels
// Notes:   supply good ramps so reset mode is visible
`timescale 1ns/10ps
`default_nettype none
module pins_model (
  input  wire logic                      core_clk,
  input  wire pmode_pkg::power_ctrl_type power_ctrl,
  input  wire logic                      hold_bad,
  input  wire pmode_pkg::wake_in_type    wake_cmd,
  output pmode_pkg::wake_in_type         wake_in,
  output logic                           core_supply_good
);
  logic [3:0] ramp_r = 4'h0;
  // regulator needs time to settle, never instantly good
  always_ff @(posedge core_clk) begin
    if (!power_ctrl.core_supply_on || hold_bad) begin
      ramp_r <= 4'h0;
    end else if (ramp_r != 4'hf) begin
      ramp_r <= ramp_r + 4'h1;
    end
  end
  assign core_supply_good = (ramp_r >= 4'h8);
  assign wake_in          = wake_cmd;
endmodule // pins_model
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: directed tests of mode sequencing and wake-up
// Assumes: register port, one-cycle read data
// Notes:   period register 1 keeps cyclic runs short
`timescale 1ns/10ps
`default_nettype none
`include "pmode_defs.svh"
module testbench;
  logic                      core_clk;
  logic                      sys_rst;
  logic [7:0]                reg_addr;
  logic [31:0]               reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [31:0]               reg_rdata;
  pmode_pkg::wake_in_type    wake_cmd;
  pmode_pkg::wake_in_type    wake_in;
  logic                      core_supply_good;
  logic                      watchdog_fail;
  logic                      hold_bad;
  pmode_pkg::power_ctrl_type power_ctrl;
  logic                      high_side_output;
  logic                      external_sensor_supply;
  logic                      irq;
  logic [31:0]               rv;
  int                        n_fail;
  int                        tests_run;
  power_mode_wakeup_control i_power_mode_wakeup_control (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_in(wake_in),
    .core_supply_good(core_supply_good), .watchdog_fail(watchdog_fail),
    .power_ctrl(power_ctrl), .high_side_output(high_side_output),
    .external_sensor_supply(external_sensor_supply), .irq(irq));
  pins_model i_pins_model (.core_clk(core_clk), .power_ctrl(power_ctrl), .hold_bad(hold_bad),
    .wake_cmd(wake_cmd), .wake_in(wake_in), .core_supply_good(core_supply_good));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe dropped then one idle edge, so no double drive per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    int i = 0;
    rd(`PM_STATUS);
    while (rv[2:0] !== m && i < lim) begin
      rd(`PM_STATUS);
      i++;
    end
    chk({29'h0, rv[2:0]}, {29'h0, m});
  endtask
  task automatic wd_pulse();
    watchdog_fail <= 1'b1;
    @(posedge core_clk);
    watchdog_fail <= 1'b0;
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    #1 chk({30'h0, power_ctrl.core_supply_on, power_ctrl.cpu_reset}, 32'h3);
    @(posedge core_clk);
    rd(`PM_WAKE_EN);
    chk(rv, 32'h43f);
    rd(`PM_EDGE_RISE);
    chk(rv, 32'h7ff);
    rd(8'h3c);
    chk(rv, 32'h0);
    wait_mode(3'h1, 50);
    chk({30'h0, power_ctrl.modules_on, power_ctrl.meas_on}, 32'h3);
    chk({22'h0, power_ctrl}, 32'h3be);
    $display("test reset done");
  endtask
  task automatic t_stop();
    wr(`PM_WAKE_MASK, 32'h1);
    wr(`PM_MODE_CTRL, 32'h1);
    wait_mode(3'h2, 20);
    chk({29'h0, power_ctrl.core_supply_on, power_ctrl.core_supply_low,
         power_ctrl.pll_on}, 32'h6);
    chk({22'h0, power_ctrl}, 32'h3c0);
    wake_cmd.gpio <= 4'h1;
    repeat (20) @(posedge core_clk);
    wait_mode(3'h2, 0);
    wake_cmd.lin <= 1'b1;
    wait_mode(3'h1, 20);
    rd(`PM_WAKE_STAT);
    chk(rv & 32'h41, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`PM_WAKE_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test stop done");
  endtask
  task automatic t_edges();
    wake_cmd <= '0;
    repeat (10) @(posedge core_clk);
    wr(`PM_WAKE_STAT, 32'h7ff);
    wr(`PM_WAKE_EN, 32'h07f);
    wr(`PM_EDGE_RISE, 32'h7bf);
    wr(`PM_EDGE_FALL, 32'h040);
    wr(`PM_MODE_CTRL, 32'h1);
    wait_mode(3'h2, 20);
    wake_cmd.gpio <= 4'h1;
    repeat (20) @(posedge core_clk);
    wait_mode(3'h2, 0);
    wake_cmd.gpio <= 4'h0;
    wait_mode(3'h1, 20);
    rd(`PM_WAKE_STAT);
    chk(rv, 32'h40);
    chk({31'h0, irq}, 32'h0);
    wr(`PM_WAKE_STAT, 32'h40);
    $display("test edges done");
  endtask
  task automatic t_sleep();
    wr(`PM_MODE_CTRL, 32'h3);
    wait_mode(3'h3, 20);
    chk({31'h0, power_ctrl.core_supply_on}, 32'h0);
    chk({22'h0, power_ctrl}, 32'h0);
    wake_cmd.gpio <= 4'h1;
    repeat (10) @(posedge core_clk);
    wake_cmd.gpio <= 4'h0;
    repeat (20) @(posedge core_clk);
    wait_mode(3'h3, 0);
    wake_cmd.mon <= 5'h1;
    wait_mode(3'h1, 100);
    chk({31'h0, rv[7]}, 32'h1);
    wr(`PM_WAKE_STAT, 32'h7ff);
    $display("test sleep done");
  endtask
  task automatic t_watchdog();
    hold_bad <= 1'b1;
    sys_rst  <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    repeat (4) wd_pulse();
    wait_mode(3'h0, 0);
    wd_pulse();
    wait_mode(3'h3, 10);
    hold_bad <= 1'b0;
    wake_cmd.mon <= 5'h3;
    wait_mode(3'h1, 100);
    $display("test watchdog done");
  endtask
  task automatic t_cyclic();
    wr(`PM_WAKE_STAT, 32'h7ff);
    wr(`PM_CYC_PERIOD, 32'h1);
    wr(`PM_CYC_CFG, 32'h1);
    wr(`PM_MODE_CTRL, 32'h1);
    wait_mode(3'h2, 20);
    wait_mode(3'h1, 700);
    rd(`PM_WAKE_STAT);
    chk(rv, 32'h400);
    $display("test cyclic done");
  endtask
  // monitor edges off, so only the window compare can wake
  task automatic t_sense();
    int i = 0;
    wr(`PM_WAKE_STAT, 32'h7ff);
    wr(`PM_EDGE_RISE, 32'h001);
    wr(`PM_CYC_CFG, 32'ha);
    wr(`PM_MODE_CTRL, 32'h1);
    while (high_side_output !== 1'b1 && i < 1500) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk({30'h0, high_side_output, external_sensor_supply}, 32'h3);
    @(posedge core_clk);
    wake_cmd.mon <= 5'h1;
    wait_mode(3'h1, 1000);
    rd(`PM_WAKE_STAT);
    chk(rv, 32'h0);
    wr(`PM_SENSE_REF, 32'h002);
    wr(`PM_CYC_CFG, 32'h6);
    wr(`PM_MODE_CTRL, 32'h1);
    wait_mode(3'h2, 20);
    wait_mode(3'h1, 1100);
    $display("test sense done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // whole run is about 5k cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end
  initial begin
    n_fail        = 0;
    tests_run     = 0;
    sys_rst       = 1'b1;
    reg_addr      = 8'h00;
    reg_wdata     = 32'h0;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    wake_cmd      = '0;
    watchdog_fail = 1'b0;
    hold_bad      = 1'b0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_stop();
    t_edges();
    t_sleep();
    t_watchdog();
    t_cyclic();
    t_sense();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
